// *** rtl/oac_div_sync.sv ***
// output divider hold and release sequencing
// assumes sync_next is the value the sync bit takes at this edge
`timescale 1ns/1ps
`include "oac_regs.svh"
module oac_div_sync (
  // clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     ce,
  // sync bit, next state
  input  wire logic                     sync_next,
  // divider control
  output oac_pkg::oac_div_ctl_type      div_ctl
);

  oac_pkg::oac_sync_state_type state_reg;
  oac_pkg::oac_sync_state_type state_next;

  always_comb begin
    case (state_reg)
      oac_pkg::SYNC_RUN:
        state_next = sync_next ? oac_pkg::SYNC_HOLD : oac_pkg::SYNC_RUN;
      oac_pkg::SYNC_HOLD:
        state_next = sync_next ? oac_pkg::SYNC_HOLD : oac_pkg::SYNC_RELEASE;
      oac_pkg::SYNC_RELEASE:
        state_next = sync_next ? oac_pkg::SYNC_HOLD : oac_pkg::SYNC_RUN;
      default:
        state_next = oac_pkg::SYNC_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst)
      state_reg <= oac_pkg::SYNC_RUN;
    else if (ce)
      state_reg <= state_next;
  end

  // every divider leaves reset at the same edge; coarse clear and
  // fine apply ride on that single release cycle
  assign div_ctl.div_reset     = (state_reg == oac_pkg::SYNC_HOLD);
  assign div_ctl.release_pulse = (state_reg == oac_pkg::SYNC_RELEASE);
  assign div_ctl.coarse_clear  = (state_reg == oac_pkg::SYNC_RELEASE);
  assign div_ctl.fine_apply    = (state_reg == oac_pkg::SYNC_RELEASE);

endmodule : oac_div_sync

// *** rtl/oac_pkg.sv ***
// types shared by the output source and analog pll control block
// assumes the constants header is included by the modules themselves
package oac_pkg;

  // ----------------------------------------
  // register port request
  // ----------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } oac_reg_req_type;

  // one-hot source route per output
  typedef struct packed {
    logic pll;
    logic out2;
    logic out3;
    logic ref0;
    logic ref1;
    logic xtal;
  } oac_src_route_type;

  // ----------------------------------------
  // divider sync control
  // ----------------------------------------
  typedef enum logic [2:0] {
    SYNC_RUN     = 3'h1,
    SYNC_HOLD    = 3'h2,
    SYNC_RELEASE = 3'h4
  } oac_sync_state_type;

  typedef struct packed {
    logic div_reset;
    logic release_pulse;
    logic coarse_clear;
    logic fine_apply;
  } oac_div_ctl_type;

  // ----------------------------------------
  // analog pll settings
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] charge_pump_current;
    logic [9:0] charge_pump_ua;
    logic [1:0] loop_series_resistor;
    logic [1:0] loop_parallel_capacitor;
    logic       loop_second_pole;
    logic       lock_count_accuracy;
    logic       lock_manual_override;
    logic       manual_vco_choice;
    logic [4:0] lock_code;
    logic       synthesizer_mode;
  } oac_apll_cfg_type;

endpackage : oac_pkg

// *** rtl/oac_regs.svh ***
// constant definitions for output source and analog pll control
// assumes byte-wide registers on a 16-bit byte address port
`ifndef OAC_REGS_SVH
`define OAC_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define OAC_ADDR_SYNC        16'h00A8
`define OAC_ADDR_SEL45       16'h00A9
`define OAC_ADDR_SEL67       16'h00AA
`define OAC_ADDR_CPLF        16'h00AC
`define OAC_ADDR_SYNLK       16'h00AD
`define OAC_ADDR_VCO1        16'h00AE
`define OAC_ADDR_VCO2        16'h00AF
`define OAC_NUM_REGS         7

// ----------------------------------------
// reset values
// ----------------------------------------
`define OAC_RST_SYNC         8'h00
`define OAC_RST_SEL45        8'h20
`define OAC_RST_SEL67        8'h50
`define OAC_RST_CPLF         8'h8B
`define OAC_RST_SYNLK        8'h02
`define OAC_RST_VCO1         8'h2B
`define OAC_RST_VCO2         8'h00
`define OAC_RD_UNMAPPED      8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define OAC_SYNC_BIT         3
`define OAC_SEL_LO           2:0
`define OAC_SEL_HI           6:4
`define OAC_CP_CUR           7:5
`define OAC_LF_RS            4:3
`define OAC_LF_CP            2:1
`define OAC_LF_POLE          0
`define OAC_SYNTHESIZER_MODE_BIT     3
`define OAC_LOCK_ACC_BIT     1
`define OAC_LOCK_MAN_BIT     0
`define OAC_VCO_CHOICE_BIT   5
`define OAC_LOCK_CODE        4:0

// ----------------------------------------
// source codes and scaling
// ----------------------------------------
`define OAC_SRC_PLL          3'h0
`define OAC_SRC_OUT2         3'h2
`define OAC_SRC_OUT3         3'h3
`define OAC_SRC_REF0         3'h4
`define OAC_SRC_REF1         3'h5
`define OAC_SRC_XTAL         3'h7
`define OAC_CP_STEP_UA       10'h06E
`define OAC_CP_CODE_ONE      10'h001
`define OAC_CP_PAD           7'h00

`endif

// *** rtl/oac_src_mux.sv ***
// decodes the four output source select fields into one-hot routes
// assumes select values arrive as next-state values from the register file
`timescale 1ns/1ps
`include "oac_regs.svh"
module oac_src_mux (
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  ce,
  // selects, next state
  input  wire logic [3:0][2:0]       sel_next,
  // routes
  output oac_pkg::oac_src_route_type route [4],
  output logic      [3:0]            sel_reserved
);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_out
      oac_pkg::oac_src_route_type dec;
      wire logic [2:0] s = sel_next[g];
      // reserved codes leave the output with no source at all
      assign dec.pll  = (s == `OAC_SRC_PLL);
      assign dec.out2 = (s == `OAC_SRC_OUT2);
      assign dec.out3 = (s == `OAC_SRC_OUT3);
      assign dec.ref0 = (s == `OAC_SRC_REF0);
      assign dec.ref1 = (s == `OAC_SRC_REF1);
      assign dec.xtal = (s == `OAC_SRC_XTAL);
      wire logic none = ~|dec;

      always_ff @(posedge mclk) begin
        if (srst) begin
          route[g]        <= '0;
          sel_reserved[g] <= 1'b0;
        end else if (ce) begin
          route[g]        <= dec;
          sel_reserved[g] <= none;
        end
      end
    end
  endgenerate

endmodule : oac_src_mux

// *** rtl/oac_top.sv ***
// output source selection and analog pll configuration registers
// assumes a byte-wide register port on mclk, driven by on-chip logic
// (the serial bus front end), so no input synchronisers are needed
`timescale 1ns/1ps
`include "oac_regs.svh"
module oac_top (
  // clock, reset, enable
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      ce,
  // register port
  input  wire oac_pkg::oac_reg_req_type  reg_req,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_rvalid,
  // output source routes, outputs 4 to 7
  output oac_pkg::oac_src_route_type     out_route [4],
  output logic      [3:0]                out_sel_reserved,
  // divider sync
  output oac_pkg::oac_div_ctl_type       div_ctl,
  // analog pll
  output oac_pkg::oac_apll_cfg_type      apll_cfg
);

  // ----------------------------------------
  // register table
  // ----------------------------------------
  localparam logic [15:0] REG_ADDR [`OAC_NUM_REGS] = '{
    `OAC_ADDR_SYNC, `OAC_ADDR_SEL45, `OAC_ADDR_SEL67, `OAC_ADDR_CPLF,
    `OAC_ADDR_SYNLK, `OAC_ADDR_VCO1, `OAC_ADDR_VCO2};
  localparam logic [7:0] REG_RST [`OAC_NUM_REGS] = '{
    `OAC_RST_SYNC, `OAC_RST_SEL45, `OAC_RST_SEL67, `OAC_RST_CPLF,
    `OAC_RST_SYNLK, `OAC_RST_VCO1, `OAC_RST_VCO2};

  localparam int I_SYNC  = 0;
  localparam int I_SEL45 = 1;
  localparam int I_SEL67 = 2;
  localparam int I_CPLF  = 3;
  localparam int I_SYNLK = 4;
  localparam int I_VCO1  = 5;
  localparam int I_VCO2  = 6;

  logic [7:0]                cfg_reg  [`OAC_NUM_REGS];
  logic [7:0]                cfg_next [`OAC_NUM_REGS];
  logic [`OAC_NUM_REGS-1:0]  hit;

  // ----------------------------------------
  // storage, one entry per register
  // ----------------------------------------
  // reserved bits are stored as written; software keeps them zero
  genvar i;
  generate
    for (i = 0; i < `OAC_NUM_REGS; i++) begin : g_reg
      assign hit[i]      = (reg_req.addr == REG_ADDR[i]);
      wire logic wr_hit  = reg_req.wr & hit[i];
      assign cfg_next[i] = wr_hit ? reg_req.wdata : cfg_reg[i];

      always_ff @(posedge mclk) begin
        if (srst)
          cfg_reg[i] <= REG_RST[i];
        else if (ce)
          cfg_reg[i] <= cfg_next[i];
      end
    end
  endgenerate

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = `OAC_RD_UNMAPPED;
    for (int k = 0; k < `OAC_NUM_REGS; k++) begin
      if (hit[k])
        rd_mux = cfg_reg[k];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata  <= `OAC_RD_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rdata  <= reg_req.rd ? rd_mux : reg_rdata;
      reg_rvalid <= reg_req.rd;
    end
  end

  // ----------------------------------------
  // output source select
  // ----------------------------------------
  // decoding the next value keeps the route in step with the stored field
  wire logic [3:0][2:0] sel_next = {
    cfg_next[I_SEL67][`OAC_SEL_HI], cfg_next[I_SEL67][`OAC_SEL_LO],
    cfg_next[I_SEL45][`OAC_SEL_HI], cfg_next[I_SEL45][`OAC_SEL_LO]};

  oac_src_mux u_src_mux (
    .mclk         (mclk),
    .srst         (srst),
    .ce           (ce),
    .sel_next     (sel_next),
    .route        (out_route),
    .sel_reserved (out_sel_reserved)
  );

  // ----------------------------------------
  // divider sync
  // ----------------------------------------
  oac_div_sync u_div_sync (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .sync_next (cfg_next[I_SYNC][`OAC_SYNC_BIT]),
    .div_ctl   (div_ctl)
  );

  // ----------------------------------------
  // analog pll settings
  // ----------------------------------------
  wire logic [7:0] cplf  = cfg_next[I_CPLF];
  wire logic [7:0] synlk = cfg_next[I_SYNLK];
  wire logic [7:0] vco1  = cfg_next[I_VCO1];
  wire logic [7:0] vco2  = cfg_next[I_VCO2];

  wire logic [2:0] cp_code = cplf[`OAC_CP_CUR];
  // equal steps: (code + 1) x step, so 110 uA at 000 and 880 uA at 111
  wire logic [9:0] cp_ua = 10'(({`OAC_CP_PAD, cp_code} + `OAC_CP_CODE_ONE)
                                * `OAC_CP_STEP_UA);
  wire logic       vco_choice = vco1[`OAC_VCO_CHOICE_BIT];
  wire logic [4:0] chosen_code = vco_choice ? vco1[`OAC_LOCK_CODE]
                                            : vco2[`OAC_LOCK_CODE];

  oac_pkg::oac_apll_cfg_type apll_next;

  assign apll_next.charge_pump_current     = cp_code;
  assign apll_next.charge_pump_ua          = cp_ua;
  assign apll_next.loop_series_resistor    = cplf[`OAC_LF_RS];
  assign apll_next.loop_parallel_capacitor = cplf[`OAC_LF_CP];
  assign apll_next.loop_second_pole        = cplf[`OAC_LF_POLE];
  assign apll_next.lock_count_accuracy     = synlk[`OAC_LOCK_ACC_BIT];
  assign apll_next.lock_manual_override    = synlk[`OAC_LOCK_MAN_BIT];
  assign apll_next.manual_vco_choice       = vco_choice;
  assign apll_next.lock_code               = chosen_code;
  assign apll_next.synthesizer_mode        = synlk[`OAC_SYNTHESIZER_MODE_BIT];

  // registered so the analog side never sees decode glitches
  always_ff @(posedge mclk) begin
    if (srst)
      apll_cfg <= '0;
    else if (ce)
      apll_cfg <= apll_next;
  end

endmodule : oac_top

// *** verification/oac_monitor.sv ***
// port-level checks for oac_top
// assumes oac_pkg is compiled first; attached by the bind at the foot
`timescale 1ns/1ps
module oac_monitor (
  // clock, reset, enable
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic                       ce,
  // register port
  input wire oac_pkg::oac_reg_req_type   reg_req,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rvalid,
  // outputs
  input wire oac_pkg::oac_src_route_type out_route [4],
  input wire logic [3:0]                 out_sel_reserved,
  input wire oac_pkg::oac_div_ctl_type   div_ctl,
  input wire oac_pkg::oac_apll_cfg_type  apll_cfg
);
  localparam logic [5:0] RT [8] = '{6'h20, 6'h00, 6'h10, 6'h08, 6'h04, 6'h02, 6'h00, 6'h01};
  wire wa = ce && reg_req.wr;
  wire a8 = reg_req.addr == 16'h00A8;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  AST_SYNC_SET: assert property (wa && a8 && reg_req.wdata[3] |=> div_ctl.div_reset)
    else $error("divider hold missing");
  AST_SYNC_STAY: assert property (div_ctl.div_reset && !(wa && a8) |=> div_ctl.div_reset)
    else $error("divider hold dropped");
  AST_RELEASE: assert property (div_ctl.div_reset && wa && a8 && !reg_req.wdata[3]
    |=> div_ctl == 4'h7) else $error("divider release wrong");
  AST_PULSE_ONE: assert property (div_ctl.release_pulse && ce |=> !div_ctl.release_pulse)
    else $error("release pulse too long");
  AST_SEL4: assert property (wa && reg_req.addr == 16'h00A9
    |=> out_route[0] == RT[$past(reg_req.wdata[2:0])]) else $error("output4 route wrong");
  AST_SEL7_RSV: assert property (wa && reg_req.addr == 16'h00AA
    |=> out_sel_reserved[3] == (RT[$past(reg_req.wdata[6:4])] == 6'h00))
    else $error("output7 reserved flag wrong");
  AST_RST_SEL: assert property ($fell(srst) && ce && !(wa && (reg_req.addr == 16'h00A9 ||
    reg_req.addr == 16'h00AA)) |=> out_route[0] == 6'h20 && out_route[1] == 6'h10 &&
    out_route[2] == 6'h20 && out_route[3] == 6'h02)
    else $error("reset routes wrong");
  AST_CP_UA: assert property (!$past(srst) |-> apll_cfg.charge_pump_ua ==
    ({7'h00, apll_cfg.charge_pump_current} + 10'h001) * 10'h06E) else $error("pump current wrong");
  AST_VCO: assert property (wa && reg_req.addr == 16'h00AE
    |=> apll_cfg.manual_vco_choice == $past(reg_req.wdata[5]) && (!apll_cfg.manual_vco_choice
    || apll_cfg.lock_code == $past(reg_req.wdata[4:0]))) else $error("vco lock code wrong");
  AST_SYNLK: assert property (wa && reg_req.addr == 16'h00AD
    |=> {apll_cfg.synthesizer_mode, apll_cfg.lock_count_accuracy, apll_cfg.lock_manual_override}
    == {$past(reg_req.wdata[3]), $past(reg_req.wdata[1:0])}) else $error("mode bits wrong");
  AST_RD: assert property (ce && reg_req.rd |=> reg_rvalid)
    else $error("read answer missing");
endmodule : oac_monitor

bind oac_top oac_monitor u_oac_monitor (.mclk(mclk), .srst(srst), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .out_route(out_route),
  .out_sel_reserved(out_sel_reserved), .div_ctl(div_ctl), .apll_cfg(apll_cfg));

// *** verification/oac_top_test.sv ***
// self-checking bench for oac_top
// assumes oac_pkg and the bound monitor are compiled first
`timescale 1ns/1ps
module oac_top_test;
  logic                       mclk = 1'b0;
  logic                       srst = 1'b1;
  logic                       ce = 1'b1;
  oac_pkg::oac_reg_req_type   reg_req = '0;
  logic [7:0]                 reg_rdata;
  logic                       reg_rvalid;
  oac_pkg::oac_src_route_type out_route [4];
  logic [3:0]                 out_sel_reserved;
  oac_pkg::oac_div_ctl_type   div_ctl;
  oac_pkg::oac_apll_cfg_type  apll_cfg;
  int err_total = 0;
  int num_checks = 0;
  int seed = 5796;
  logic [7:0] exp_q [$];
  logic [7:0] msk_q [$];
  logic [5:0] rt [8] = '{6'h20, 6'h00, 6'h10, 6'h08, 6'h04, 6'h02, 6'h00, 6'h01};
  logic [15:0] ra [7] = '{16'h00A8, 16'h00A9, 16'h00AA, 16'h00AC, 16'h00AD, 16'h00AE, 16'h00AF};
  logic [7:0] rv [7] = '{8'h00, 8'h20, 8'h50, 8'h8B, 8'h02, 8'h2B, 8'h00};
  // reserved bits masked off, their read value is undefined
  logic [7:0] rm [7] = '{8'h08, 8'h77, 8'h77, 8'hFF, 8'h0B, 8'h3F, 8'h1F};
  logic [7:0] ac, ad, ae, af;
  wire logic [23:0] routes = {out_route[0], out_route[1], out_route[2], out_route[3]};

  always #20 mclk = ~mclk;

  oac_top u_oac_top (.mclk(mclk), .srst(srst), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .out_route(out_route),
    .out_sel_reserved(out_sel_reserved), .div_ctl(div_ctl), .apll_cfg(apll_cfg));

  // ----
  // drivers and comparison
  // ----
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] rdata expected %h seen %h", e, g);
    end
  endtask : chk_rd

  task automatic chk_route(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_route

  task automatic chk_rsv(input string n, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_rsv

  task automatic chk_div(input string n, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_div

  task automatic chk_apll(input string n, input oac_pkg::oac_apll_cfg_type e,
                          input oac_pkg::oac_apll_cfg_type g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_apll

  task automatic chk_cnt(input string n, input int e, input int g);
    num_checks++;
    if (g != e) begin
      err_total++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_cnt

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge mclk);
  endtask : rd

  task automatic idle(input int n);
    reg_req <= '0;
    repeat (n) @(posedge mclk);
  endtask : idle

  function automatic oac_pkg::oac_apll_cfg_type ea(input logic [7:0] c, s, v1, v2);
    ea.charge_pump_current = c[7:5];
    ea.charge_pump_ua = ({7'h00, c[7:5]} + 10'h001) * 10'h06E;
    ea.loop_series_resistor = c[4:3];
    ea.loop_parallel_capacitor = c[2:1];
    ea.loop_second_pole = c[0];
    ea.lock_count_accuracy = s[1];
    ea.lock_manual_override = s[0];
    ea.manual_vco_choice = v1[5];
    ea.lock_code = v1[5] ? v1[4:0] : v2[4:0];
    ea.synthesizer_mode = s[3];
  endfunction : ea

  // one pulse of rvalid per read; an answer with no read pending is a mismatch
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk_cnt("rvalid", 0, 1);
      else
        chk_rd(exp_q.pop_front(), reg_rdata & msk_q.pop_front());
    end
  end

  task automatic t_reset;
    srst <= 1'b1;
    idle(1);
    srst <= 1'b0;
    idle(2);
    @(negedge mclk);
    chk_route("routes", {rt[0], rt[2], rt[0], rt[5]}, routes);
    chk_apll("apll", ea(8'h8B, 8'h02, 8'h2B, 8'h00), apll_cfg);
    chk_div("divctl", 4'h0, div_ctl);
    @(posedge mclk);
    for (int i = 0; i < 7; i++)
      rd(ra[i], rv[i], rm[i]);
    idle(3);
    $display("test reset done");
  endtask : t_reset

  // ----
  // main sequence
  // ----
  initial begin
    @(posedge mclk);
    t_reset();
    // references assumed slow enough for direct routing
    for (int c = 0; c < 8; c++) begin
      wr(16'h00A9, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr(16'h00AA, {1'b0, ~3'(c), 1'b0, 3'(c)});
      idle(1);
      @(negedge mclk);
      chk_route("routes", {rt[c], rt[c], rt[c], rt[~3'(c)]}, routes);
      chk_rsv("rsv", {rt[~3'(c)] == 0, {3{rt[c] == 0}}}, out_sel_reserved);
      @(posedge mclk);
    end
    wr(16'h01A9, 8'h77);
    rd(16'h00A9, 8'h77, 8'h77);
    rd(16'h0100, 8'h00, 8'hFF);
    idle(3);
    $display("test select done");
    wr(16'h00A8, 8'h08);
    idle(3);
    @(negedge mclk);
    chk_div("hold", 4'h8, div_ctl);
    @(posedge mclk);
    wr(16'h00A8, 8'h00);
    @(negedge mclk);
    chk_div("release", 4'h7, div_ctl);
    @(posedge mclk);
    idle(1);
    @(negedge mclk);
    chk_div("after", 4'h0, div_ctl);
    @(posedge mclk);
    wr(16'h00A8, 8'h08);
    idle(2);
    wr(16'h00A8, 8'h00);
    wr(16'h00A8, 8'h08);
    @(negedge mclk);
    chk_div("rehold", 4'h8, div_ctl);
    @(posedge mclk);
    wr(16'h00A8, 8'h00);
    idle(2);
    $display("test sync done");
    // dpll state force lives outside this block
    repeat (24) begin
      ac = 8'($random(seed));
      ad = 8'($random(seed)) & 8'h0B;
      ae = 8'($random(seed)) & 8'h3F;
      af = 8'($random(seed)) & 8'h1F;
      wr(16'h00AC, ac);
      wr(16'h00AD, ad);
      wr(16'h00AE, ae);
      wr(16'h00AF, af);
      rd(16'h00AC, ac, 8'hFF);
      rd(16'h00AD, ad, 8'h0B);
      rd(16'h00AE, ae, 8'h3F);
      rd(16'h00AF, af, 8'h1F);
      idle(1);
      @(negedge mclk);
      chk_apll("apll", ea(ac, ad, ae, af), apll_cfg);
      @(posedge mclk);
    end
    ce <= 1'b0;
    wr(16'h00AC, ~ac);
    idle(1);
    ce <= 1'b1;
    @(negedge mclk);
    chk_apll("frozen", ea(ac, ad, ae, af), apll_cfg);
    @(posedge mclk);
    $display("test apll done");
    t_reset();
    chk_cnt("pending", 0, exp_q.size());
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict();
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
endmodule : oac_top_test
